// ==== src/burst_addr_gen.sv ====
// Burst column address generator: block select, start offset, ordering
`timescale 1ns/1ps
`default_nettype none
module burst_addr_gen
  import sdram_cfg_pkg::*;
(
  // Burst shape
  input  wire logic [COL_W-1:0] startCol,
  input  wire logic [COL_W-1:0] blockMask,
  input  wire logic             interleave,
  input  wire logic [COL_W-1:0] beatCount,
  // Result
  output logic      [COL_W-1:0] column
);

  logic [COL_W-1:0] offSeq;
  logic [COL_W-1:0] offInt;
  logic [COL_W-1:0] offset;

  always_comb begin
    offSeq = (startCol + beatCount) & blockMask;
    offInt = (startCol ^ beatCount) & blockMask;
    offset = interleave ? offInt : offSeq;
    column = (startCol & ~blockMask) | offset;
  end

endmodule : burst_addr_gen
`default_nettype wire

// ==== src/sdram_cfg_pkg.sv ====
// Package: configuration word layout, encodings and timing constants
package sdram_cfg_pkg;

  // ----------------------------------------
  // Configuration word layout
  // ----------------------------------------
  localparam int CFG_W        = 13;
  localparam int SPAN_LSB     = 0;
  localparam int SPAN_W       = 3;
  localparam int ORDER_BIT    = 3;
  localparam int LAT_LSB      = 4;
  localparam int LAT_W        = 3;
  localparam int OPMODE_LSB   = 7;
  localparam int OPMODE_W     = 2;
  localparam int WBURST_BIT   = 9;
  localparam logic [CFG_W-1:0] CFG_RESET = 13'h0020;

  // ----------------------------------------
  // Field encodings
  // ----------------------------------------
  localparam logic [2:0] SPAN_1    = 3'h0;
  localparam logic [2:0] SPAN_2    = 3'h1;
  localparam logic [2:0] SPAN_4    = 3'h2;
  localparam logic [2:0] SPAN_8    = 3'h3;
  localparam logic [2:0] SPAN_PAGE = 3'h7;
  localparam logic [2:0] LAT_2     = 3'h2;
  localparam logic [2:0] LAT_3     = 3'h3;
  localparam logic [1:0] OPMODE_NORMAL = 2'h0;

  // ----------------------------------------
  // Geometry (x16 column width) and commands
  // ----------------------------------------
  localparam int COL_W  = 9;
  localparam int ADDR_W = 13;
  localparam logic [COL_W-1:0] COL_ZERO = 9'h000;
  localparam logic [COL_W-1:0] COL_ONE  = 9'h001;
  localparam logic [COL_W-1:0] MASK_1   = 9'h000;
  localparam logic [COL_W-1:0] MASK_2   = 9'h001;
  localparam logic [COL_W-1:0] MASK_4   = 9'h003;
  localparam logic [COL_W-1:0] MASK_8   = 9'h007;
  localparam logic [COL_W-1:0] MASK_PG  = 9'h1FF;
  localparam logic [9:0] LEN_PAGE = 10'h200;

  // {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CMD_NOP    = 3'h7;
  localparam logic [2:0] CMD_READ   = 3'h5;
  localparam logic [2:0] CMD_WRITE  = 3'h4;
  localparam logic [2:0] CMD_STOP   = 3'h6;
  localparam logic [2:0] CMD_CFGLD  = 3'h0;
  localparam logic [1:0] BANK_CFG   = 2'h0;

  // Read data path pipeline depth (longest latency)
  localparam int LAT_PIPE = 3;

endpackage : sdram_cfg_pkg

// ==== src/sdram_mode_register_config.sv ====
// Configuration word register and burst/latency sequencing of the SDRAM
//
// Function
// - Decode span, order, latency, mode, write-burst fields
// - Word changes only on configuration-load command
// - At most burst-span columns per access
// - Spans 1,2,4,8 both orders; page sequential
// - Full page runs until burst-stop command
// - Burst stays in aligned block, wrapping
// - Block from column bits above span bits
// - Low column bits pick first location
// - Full page wraps within the row
// - Order bit picks sequential or interleaved
// - First read data delayed by latency
// - Drive from edge n+m-1, valid n+m
// - Zero operating-mode bits select normal operation
// - Normal mode applies span to both directions
// - Write-burst bit set makes writes single
// - Span one: addressed column, order ignored
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_register_config
  import sdram_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  // Command pins (active low strobes), bank and address
  input  wire logic              chipSel_n,
  input  wire logic              rowStrobe_n,
  input  wire logic              colStrobe_n,
  input  wire logic              writeEn_n,
  input  wire logic [1:0]        bankSel,
  input  wire logic [ADDR_W-1:0] addr,
  // Column access to the array
  output logic                   colValid,
  output logic                   colWrite,
  output logic      [COL_W-1:0]  colAddr,
  // Read data timing
  output logic                   dataDrive,
  output logic                   dataValid,
  // Configuration state
  output logic      [CFG_W-1:0]  configWord,
  output logic                   modeNormal
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [18:0] pinMeta_r;
  logic [18:0] pinSync_r;
  logic [18:0] pinRaw;
  logic        csN;
  logic [2:0]  cmd;
  logic [1:0]  bank;
  logic [ADDR_W-1:0] adr;

  assign pinRaw = {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n, bankSel, addr};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pinMeta_r <= '1;
      pinSync_r <= '1;
    end else if (clkEn) begin
      pinMeta_r <= pinRaw;
      pinSync_r <= pinMeta_r;
    end
  end

  assign csN  = pinSync_r[18];
  assign cmd  = pinSync_r[17:15];
  assign bank = pinSync_r[14:13];
  assign adr  = pinSync_r[12:0];

  // ----------------------------------------
  // Configuration word
  // ----------------------------------------
  logic [CFG_W-1:0] cfg_r;
  logic [CFG_W-1:0] cfg_nxt;
  logic             isLoad;

  // Bank lines other than zero address other mode words, not this one
  assign isLoad = !csN && cmd == CMD_CFGLD && bank == BANK_CFG;

  always_comb begin
    cfg_nxt = cfg_r;
    if (isLoad) begin
      cfg_nxt = adr;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_r <= CFG_RESET;
    end else if (clkEn) begin
      cfg_r <= cfg_nxt;
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  logic [SPAN_W-1:0]   spanF;
  logic                orderF;
  logic [LAT_W-1:0]    latF;
  logic [OPMODE_W-1:0] opF;
  logic                wbF;
  logic [COL_W-1:0]    spanMask;
  logic                spanPage;
  logic [9:0]          spanLen;

  always_comb begin
    spanF  = cfg_r[SPAN_LSB +: SPAN_W];
    orderF = cfg_r[ORDER_BIT];
    latF   = cfg_r[LAT_LSB +: LAT_W];
    opF    = cfg_r[OPMODE_LSB +: OPMODE_W];
    wbF    = cfg_r[WBURST_BIT];
    spanPage = 1'b0;
    case (spanF)
      SPAN_2:    spanMask = MASK_2;
      SPAN_4:    spanMask = MASK_4;
      SPAN_8:    spanMask = MASK_8;
      SPAN_PAGE: begin
        spanMask = MASK_PG;
        spanPage = 1'b1;
      end
      // Reserved codes behave as single access
      default:   spanMask = MASK_1;
    endcase
    spanLen = {1'b0, spanMask} + 10'h001;
  end

  // ----------------------------------------
  // Burst sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {
    IDLE  = 2'b00,
    BURST = 2'b01
  } burst_e;

  burst_e           st_r, st_nxt;
  logic [COL_W-1:0] start_r, start_nxt;
  logic [COL_W-1:0] mask_r, mask_nxt;
  logic [9:0]       beat_r, beat_nxt;
  logic [9:0]       len_r, len_nxt;
  logic             ilv_r, ilv_nxt;
  logic             wr_r, wr_nxt;
  logic             page_r, page_nxt;
  logic             isRead, isWrite, isStop;
  logic [COL_W-1:0] genCol;

  always_comb begin
    isRead  = !csN && cmd == CMD_READ;
    isWrite = !csN && cmd == CMD_WRITE;
    isStop  = !csN && cmd == CMD_STOP;
  end

  burst_addr_gen burst_addr_gen_inst (
    .startCol   (start_nxt),
    .blockMask  (mask_nxt),
    .interleave (ilv_nxt),
    .beatCount  (beat_nxt[COL_W-1:0]),
    .column     (genCol)
  );

  always_comb begin
    st_nxt    = st_r;
    start_nxt = start_r;
    mask_nxt  = mask_r;
    beat_nxt  = beat_r;
    len_nxt   = len_r;
    ilv_nxt   = ilv_r;
    wr_nxt    = wr_r;
    page_nxt  = page_r;
    if (isRead || isWrite) begin
      st_nxt    = BURST;
      start_nxt = adr[COL_W-1:0];
      beat_nxt  = 10'h000;
      wr_nxt    = isWrite;
      // Interleave is meaningless for span one and unsupported for page
      ilv_nxt   = orderF && !spanPage && spanF != SPAN_1;
      if (isWrite && wbF) begin
        mask_nxt = MASK_1;
        len_nxt  = 10'h001;
        page_nxt = 1'b0;
      end else begin
        mask_nxt = spanMask;
        len_nxt  = spanLen;
        page_nxt = spanPage;
      end
    end else if (st_r == BURST) begin
      if (isStop) begin
        st_nxt = IDLE;
      end else if (!page_r && beat_r + 10'h001 >= len_r) begin
        st_nxt = IDLE;
      end else begin
        // Page beat count wraps at the row end, burst continues
        beat_nxt = page_r ? ((beat_r + 10'h001) & {1'b0, MASK_PG}) : beat_r + 10'h001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r    <= IDLE;
      start_r <= COL_ZERO;
      mask_r  <= MASK_1;
      beat_r  <= 10'h000;
      len_r   <= 10'h001;
      ilv_r   <= 1'b0;
      wr_r    <= 1'b0;
      page_r  <= 1'b0;
    end else if (clkEn) begin
      st_r    <= st_nxt;
      start_r <= start_nxt;
      mask_r  <= mask_nxt;
      beat_r  <= beat_nxt;
      len_r   <= len_nxt;
      ilv_r   <= ilv_nxt;
      wr_r    <= wr_nxt;
      page_r  <= page_nxt;
    end
  end

  // ----------------------------------------
  // Read latency pipeline
  // ----------------------------------------
  logic [LAT_PIPE-1:0] rdPipe_r, rdPipe_nxt;
  logic                beatRead;
  logic                drvNxt, vldNxt;

  assign beatRead = (st_nxt == BURST) && !wr_nxt;

  always_comb begin
    rdPipe_nxt = {rdPipe_r[LAT_PIPE-2:0], beatRead};
    // Stage k of the next value holds a beat issued k edges earlier
    if (latF == LAT_3) begin
      drvNxt = rdPipe_nxt[2];
      vldNxt = rdPipe_r[LAT_PIPE-1];
    end else begin
      drvNxt = rdPipe_nxt[1];
      vldNxt = rdPipe_nxt[2];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdPipe_r <= '0;
    end else if (clkEn) begin
      rdPipe_r <= rdPipe_nxt;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      colValid   <= 1'b0;
      colWrite   <= 1'b0;
      colAddr    <= COL_ZERO;
      dataDrive  <= 1'b0;
      dataValid  <= 1'b0;
      configWord <= CFG_RESET;
      modeNormal <= 1'b1;
    end else if (clkEn) begin
      colValid   <= st_nxt == BURST;
      colWrite   <= (st_nxt == BURST) && wr_nxt;
      colAddr    <= genCol;
      dataDrive  <= drvNxt;
      dataValid  <= vldNxt;
      configWord <= cfg_nxt;
      modeNormal <= cfg_nxt[OPMODE_LSB +: OPMODE_W] == OPMODE_NORMAL;
    end
  end

endmodule : sdram_mode_register_config
`default_nettype wire

// ==== verification/mode_cfg_sva.sv ====
// Assertion checker for configuration load and burst sequencing
`timescale 1ns/1ps
`default_nettype none
module mode_cfg_sva
  import sdram_cfg_pkg::*;
(
  // Clock and reset
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              clkEn,
  // Command pins
  input wire logic              chipSel_n,
  input wire logic              rowStrobe_n,
  input wire logic              colStrobe_n,
  input wire logic              writeEn_n,
  input wire logic [1:0]        bankSel,
  input wire logic [ADDR_W-1:0] addr,
  // Outputs
  input wire logic              colValid,
  input wire logic              colWrite,
  input wire logic [COL_W-1:0]  colAddr,
  input wire logic              dataDrive,
  input wire logic              dataValid,
  input wire logic [CFG_W-1:0]  configWord,
  input wire logic              modeNormal
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [2:0]       pins;
  logic [2:0]       span;
  logic [COL_W-1:0] mask;
  logic [COL_W-1:0] col;
  logic             rw;
  logic             load;
  logic             single;
  logic             lat3;
  // Pins presented while frozen are not commands
  assign pins = (chipSel_n || !clkEn) ? CMD_NOP : {rowStrobe_n, colStrobe_n, writeEn_n};
  assign rw = pins == CMD_READ || pins == CMD_WRITE;
  assign load = pins == CMD_CFGLD && bankSel == BANK_CFG;
  assign col = addr[COL_W-1:0];
  assign span = configWord[SPAN_LSB+:SPAN_W];
  assign lat3 = configWord[LAT_LSB+:LAT_W] == LAT_3;
  assign mask = span == SPAN_2 ? MASK_2 : span == SPAN_4 ? MASK_4 : span == SPAN_8 ? MASK_8
              : span == SPAN_PAGE ? MASK_PG : MASK_1;
  assign single = (colWrite && configWord[WBURST_BIT]) || mask == MASK_1;
  // --------------------------------
  // Properties
  // --------------------------------
  sequence s_lat2; ##1 dataDrive ##1 dataValid; endsequence
  sequence s_lat3; ##2 dataDrive ##1 dataValid; endsequence
  property p_cfg_load; load |-> ##3 configWord == $past(addr, 3); endproperty
  property p_cfg_hold; $changed(configWord) |-> $past(load, 3); endproperty
  property p_first; rw |-> ##3 colValid && colAddr == $past(col, 3); endproperty
  property p_lat2; colValid && !colWrite && !lat3 |-> s_lat2; endproperty
  property p_lat3; colValid && !colWrite && lat3 |-> s_lat3; endproperty
  property p_single; colValid && single |=> !colValid || $past(rw, 3); endproperty
  property p_block;
    colValid && $past(colValid) && !$past(rw, 3) |-> ((colAddr ^ $past(colAddr)) & ~mask) == COL_ZERO;
  endproperty
  property p_seq;
    colValid && $past(colValid) && !$past(rw, 3) && !configWord[ORDER_BIT]
      |-> ((colAddr - $past(colAddr)) & mask) == (COL_ONE & mask);
  endproperty
  property p_stop; pins == CMD_STOP |-> ##3 !colValid; endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config word not loaded");
  a_cfg_hold: assert property (p_cfg_hold) else $error("config word changed alone");
  a_first: assert property (p_first) else $error("first beat column wrong");
  a_lat2: assert property (p_lat2) else $error("latency two timing wrong");
  a_lat3: assert property (p_lat3) else $error("latency three timing wrong");
  a_single: assert property (p_single) else $error("single access ran on");
  a_block: assert property (p_block) else $error("burst left its block");
  a_seq: assert property (p_seq) else $error("sequential step wrong");
  a_stop: assert property (p_stop) else $error("burst not stopped");
endmodule // mode_cfg_sva
bind sdram_mode_register_config mode_cfg_sva mode_cfg_sva_inst (.*);
`default_nettype wire

// ==== verification/sdram_ctrl_model.sv ====
// Controller model driving the command and address pins
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model
  import sdram_cfg_pkg::*;
(
  // Clock
  input  wire logic              clock,
  // Command pins
  output logic                   chipSel_n,
  output logic                   rowStrobe_n,
  output logic                   colStrobe_n,
  output logic                   writeEn_n,
  output logic      [1:0]        bankSel,
  output logic      [ADDR_W-1:0] addr
);
  localparam int SETTLE_CYCLES = 3;
  initial begin
    chipSel_n = 1'b1;
    {rowStrobe_n, colStrobe_n, writeEn_n} = CMD_NOP;
    bankSel = 2'h0;
    addr = 13'h0000;
  end
  // One command for one edge, then idle pins with flipped address
  task automatic issue(input logic [2:0] cmd, input logic [1:0] bank, input logic [ADDR_W-1:0] a);
    chipSel_n = 1'b0;
    {rowStrobe_n, colStrobe_n, writeEn_n} = cmd;
    bankSel = bank;
    addr = a;
    @(posedge clock);
    @(negedge clock);
    {rowStrobe_n, colStrobe_n, writeEn_n} = CMD_NOP;
    bankSel = ~bank;
    addr = ~a;
  endtask
  // Caller keeps all bursts drained before a load
  task automatic loadCfg(input logic [CFG_W-1:0] v);
    // Undefined and reserved bits always go out low
    issue(CMD_CFGLD, BANK_CFG, {3'h0, v[WBURST_BIT:0]});
    repeat (SETTLE_CYCLES) @(negedge clock);
  endtask
endmodule // sdram_ctrl_model
`default_nettype wire

// ==== verification/sdram_mode_register_config_bench.sv ====
// Self-checking bench for the configuration register block
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_register_config_bench import sdram_cfg_pkg::*;;
  logic              clock, rst_n, clkEn, chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n;
  logic              colValid, colWrite, dataDrive, dataValid, modeNormal;
  logic [1:0]        bankSel;
  logic [ADDR_W-1:0] addr;
  logic [COL_W-1:0]  colAddr;
  logic [CFG_W-1:0]  configWord;
  int                nErrors = 0;
  int                nTests = 0;
  sdram_mode_register_config sdram_mode_register_config_inst (.*);
  sdram_ctrl_model sdram_ctrl_model_inst (.*);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // --------------------------------
  // Check and report
  // --------------------------------
  task automatic chk(input string what, input logic [CFG_W-1:0] seen, input logic [CFG_W-1:0] exp);
    nTests++;
    if (seen !== exp) begin
      nErrors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Load a word, start one burst and follow it beat by beat
  task automatic run(input logic [2:0] span, input logic il, input logic [2:0] lat, input logic wb,
                     input logic [2:0] cmd, input logic [COL_W-1:0] col, input int n);
    logic [CFG_W-1:0] cfg;
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] e;
    int m;
    cfg = {3'h0, wb, OPMODE_NORMAL, lat, il, span};
    mask = (span == SPAN_PAGE) ? MASK_PG : (COL_ONE << span) - COL_ONE;
    m = (lat == LAT_3) ? 3 : 2;
    sdram_ctrl_model_inst.loadCfg(cfg);
    chk("configWord", configWord, cfg);
    sdram_ctrl_model_inst.issue(cmd, BANK_CFG, {4'h0, col});
    // First beat stands from the second edge after the command edge
    repeat (2) @(negedge clock);
    for (int i = 0; i < n; i++) begin
      e = il ? (col ^ i[COL_W-1:0]) : (col + i[COL_W-1:0]);
      chk("colValid", colValid, 1'b1);
      chk("colWrite", colWrite, cmd == CMD_WRITE);
      chk("colAddr", colAddr, (col & ~mask) | (e & mask));
      chk("dataDrive", dataDrive, cmd == CMD_READ && i >= m - 1);
      chk("dataValid", dataValid, cmd == CMD_READ && i >= m);
      // Stop pins sampled two edges before the first idle cycle
      if (span == SPAN_PAGE && i == n - 3) begin
        sdram_ctrl_model_inst.issue(CMD_STOP, BANK_CFG, 13'h0000);
      end else begin
        @(negedge clock);
      end
    end
    chk("colValid", colValid, 1'b0);
    repeat (6) @(negedge clock);
  endtask
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    clkEn = 1'b1;
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    chk("configWord", configWord, CFG_RESET);
    chk("modeNormal", modeNormal, 1'b1);
    run(SPAN_2, 1'b0, LAT_2, 1'b0, CMD_READ, 9'h009, 2);
    run(SPAN_4, 1'b1, LAT_3, 1'b0, CMD_READ, 9'h1F5, 4);
    run(SPAN_8, 1'b0, LAT_2, 1'b0, CMD_READ, 9'h1FE, 8);
    run(SPAN_8, 1'b1, LAT_3, 1'b1, CMD_READ, 9'h00D, 8);
    run(SPAN_1, 1'b1, LAT_2, 1'b0, CMD_READ, 9'h033, 1);
    run(SPAN_PAGE, 1'b0, LAT_3, 1'b0, CMD_READ, 9'h1FF, 3);
    run(SPAN_4, 1'b0, LAT_2, 1'b1, CMD_WRITE, 9'h006, 1);
    run(SPAN_2, 1'b1, LAT_2, 1'b0, CMD_WRITE, 9'h003, 2);
    sdram_ctrl_model_inst.issue(CMD_CFGLD, 2'h1, 13'h0033);
    repeat (3) @(negedge clock);
    chk("configWord", configWord, 13'h0029);
    sdram_ctrl_model_inst.loadCfg(13'h0180);
    chk("modeNormal", modeNormal, 1'b0);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    chk("configWord", configWord, CFG_RESET);
    chk("modeNormal", modeNormal, 1'b1);
    // Load presented while frozen must not land
    clkEn = 1'b0;
    sdram_ctrl_model_inst.loadCfg(13'h0021);
    clkEn = 1'b1;
    repeat (4) @(negedge clock);
    chk("configWord", configWord, CFG_RESET);
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge clock);
    nErrors++;
    tally_and_finish;
  end
endmodule // sdram_mode_register_config_bench
`default_nettype wire
